// [verilog/tcc_channel.sv]
// One compare/capture channel of a 16-bit timer with a Wishbone slave.
// Assumes the counter block supplies value, direction and MAX/ZERO pulses,
// and that the partner channel's registered match pulse is wired in.
//
// The register addresses and register access over Wishbone were decided locally.
`timescale 1ns/1ns

// Notes on behaviour
// - Sync select 1 captures through synchroniser, 0 directly; unused when comparing.
// - Load select 0: buffer takes written value two clock edges after the write.
// - Load select 1: load at MAX up, zero down, either in up/down.
// - Load select 2: load when counter matches previous buffered value.
// - Load select 3: load at zero up, MAX down, match or zero up/down.
// - Load select 4: load on match and request counter reset.
// - Trigger source 0 is the pin; 2 and 3 are software low/high.
// - Edge select 1 rising, 2 falling, 3 both, 0 disables capture.
// - Software edge is a source change 2 to 3 or 3 to 2.
// - Pairing uses partner match; else own match with MAX or ZERO.
// - Output mode 0 drives the software level directly.
// - Mode 7: match deactivates, boundary or partner activates.
// - Mode 6: match toggles, boundary or partner activates.
// - Mode 5: match deactivates, also partner match when paired.
// - Mode 4: match toggles, also partner match when paired.
// - Mode 3: match activates, boundary or partner deactivates.
// - Mode 2: match toggles, boundary or partner deactivates.
// - Mode 1: match activates, also partner match when paired.
// - Polarity 1 is active low; output fields ignored in capture mode.
// - Channel mode 1 captures, 0 compares.
// - Data register holds compare value or captured counter value.
module tcc_channel import tcc_pkg::*; (
    input wire logic clk_in, // timer channel clock
    input wire logic reset_in, // async reset, active high
    input wire logic wb_cyc_in, // Wishbone cycle
    input wire logic wb_stb_in, // Wishbone strobe
    input wire logic wb_we_in, // Wishbone write enable
    input wire logic [TCC_ADR_W-1:0] wb_adr_in, // byte address
    input wire logic [3:0] wb_sel_in, // byte lanes
    input wire logic [31:0] wb_dat_in, // write data
    output logic [31:0] wb_dat_out, // read data
    output logic wb_ack_out, // acknowledge
    input wire tcc_cnt_t counter_in, // shared counter state
    input wire logic partner_match_in, // partner channel match pulse
    input wire logic capture_input_pin_in, // capture pin level
    output logic timer_output_out, // timer output pin level
    output logic match_out, // own compare match pulse
    output logic counter_reset_out, // counter reset request pulse
    output logic capture_event_out // capture happened pulse
);
    tcc_ctl_t ctl_q;
    tcc_ctl_t ctl_d;
    tcc_ctl_t ctl_wr;
    logic [15:0] cc_q, cc_d, buf_q, buf_d;
    logic [31:0] rdat_d;
    logic ack_q, load_pend_q, load_pend_d, eq_prev_q;
    logic soft_rise_q, soft_fall_q, soft_rise_d, soft_fall_d;
    logic act_q, act_d, tout_q, tout_d;
    logic match_q, cnt_rst_q, cnt_rst_d, cap_evt_q;
    logic req, wr, hit_ctl, hit_data, wr_ctl, wr_cc;
    logic cmp, cap, dir_up, dir_down, dir_ud, eq, own_match;
    logic ld_sel, load, pin_rise, pin_fall, rise_ev, fall_ev, cap_trig;
    logic bnd, other, pmatch;

    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0] sel);
        merge16 = {sel[1] ? dat[15:8] : old[15:8],
                   sel[0] ? dat[7:0] : old[7:0]};
    endfunction : merge16

    // Bus decode: one wait state, ack for one cycle, unmapped reads zero
    assign req = wb_cyc_in & wb_stb_in & ~ack_q;
    assign wr = req & wb_we_in;
    assign hit_ctl = (wb_adr_in == TCC_OFS_CTL);
    assign hit_data = (wb_adr_in == TCC_OFS_DATA);
    assign wr_ctl = wr & hit_ctl;
    assign wr_cc = wr & hit_data;
    assign ctl_wr = tcc_ctl_t'(merge16(16'(ctl_q), wb_dat_in, wb_sel_in)
                               & TCC_CTL_WMASK);
    assign ctl_d = wr_ctl ? ctl_wr : ctl_q;
    assign rdat_d = !req ? 32'h0000_0000 :
                    hit_ctl ? {16'h0000, 16'(ctl_q)} :
                    hit_data ? {16'h0000, cc_q} : 32'h0000_0000;

    assign cap = ctl_q.channel_mode;
    assign cmp = ~ctl_q.channel_mode;
    assign dir_up = (counter_in.dir_mode == TCC_DIR_UP);
    assign dir_down = (counter_in.dir_mode == TCC_DIR_DOWN);
    assign dir_ud = (counter_in.dir_mode == TCC_DIR_UPDOWN);

    // Match only on arrival, so a slow counter clock gives one pulse
    assign eq = (counter_in.value == buf_q);
    assign own_match = cmp & eq & ~eq_prev_q;

    // Buffer load timing
    assign ld_sel =
        (ctl_q.buffer_load_select == TCC_BL_WRITE) ? load_pend_q :
        (ctl_q.buffer_load_select == TCC_BL_BOUND) ?
            (dir_ud ? (counter_in.at_max | counter_in.at_zero) :
             dir_down ? counter_in.at_zero : counter_in.at_max) :
        (ctl_q.buffer_load_select == TCC_BL_MATCH) ? own_match :
        (ctl_q.buffer_load_select == TCC_BL_RETURN) ?
            (dir_ud ? (own_match | counter_in.at_zero) :
             dir_down ? counter_in.at_max : counter_in.at_zero) :
        (ctl_q.buffer_load_select == TCC_BL_MATCH_RST) ? own_match :
        1'b0;
    assign load = cmp & ld_sel;
    assign buf_d = load ? cc_q : buf_q;
    assign load_pend_d = wr_cc & cmp &
                         (ctl_q.buffer_load_select == TCC_BL_WRITE);
    assign cnt_rst_d = own_match &
        (ctl_q.buffer_load_select == TCC_BL_MATCH_RST);

    // Capture trigger
    tcc_cap_edge u_edge (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .pin_in(capture_input_pin_in),
        .sync_sel_in(ctl_q.capture_sync_select),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );
    assign soft_rise_d = wr_ctl &
        (ctl_q.capture_trigger_source == TCC_SRC_SW_LO) &
        (ctl_wr.capture_trigger_source == TCC_SRC_SW_HI);
    assign soft_fall_d = wr_ctl &
        (ctl_q.capture_trigger_source == TCC_SRC_SW_HI) &
        (ctl_wr.capture_trigger_source == TCC_SRC_SW_LO);
    assign rise_ev =
        (ctl_q.capture_trigger_source == TCC_SRC_PIN) ? pin_rise :
        ctl_q.capture_trigger_source[1] & soft_rise_q;
    assign fall_ev =
        (ctl_q.capture_trigger_source == TCC_SRC_PIN) ? pin_fall :
        ctl_q.capture_trigger_source[1] & soft_fall_q;
    assign cap_trig = cap & ((ctl_q.capture_edge_select[0] & rise_ev) |
                             (ctl_q.capture_edge_select[1] & fall_ev));
    // Capture beats a bus write in the same cycle
    assign cc_d = cap_trig ? counter_in.value :
                  wr_cc ? merge16(cc_q, wb_dat_in, wb_sel_in) : cc_q;

    // Output waveform
    assign bnd = dir_down ? counter_in.at_zero : counter_in.at_max;
    assign other = ctl_q.output_pairing ? partner_match_in : bnd;
    assign pmatch = ctl_q.output_pairing & partner_match_in;

    // Own match is applied last, so it wins a tie
    always_comb begin
        act_d = act_q;
        case (ctl_q.output_mode)
            TCC_OM_SW: begin
                act_d = ctl_q.software_output_level ^ ctl_q.output_polarity;
            end
            TCC_OM_SET: begin
                if (own_match | pmatch) act_d = 1'b1;
            end
            TCC_OM_TOG_RST: begin
                if (other) act_d = 1'b0;
                if (own_match) act_d = ~act_q;
            end
            TCC_OM_SET_RST: begin
                if (other) act_d = 1'b0;
                if (own_match) act_d = 1'b1;
            end
            TCC_OM_TOGGLE: begin
                if (own_match | pmatch) act_d = ~act_q;
            end
            TCC_OM_RESET: begin
                if (own_match | pmatch) act_d = 1'b0;
            end
            TCC_OM_TOG_SET: begin
                if (other) act_d = 1'b1;
                if (own_match) act_d = ~act_q;
            end
            TCC_OM_RST_SET: begin
                if (other) act_d = 1'b1;
                if (own_match) act_d = 1'b0;
            end
            default: act_d = act_q;
        endcase
        if (cap) act_d = act_q;
    end

    assign tout_d = cap ? tout_q :
        (ctl_q.output_mode == TCC_OM_SW) ? ctl_q.software_output_level :
        act_d ^ ctl_q.output_polarity;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            ctl_q <= tcc_ctl_t'(TCC_CTL_RESET);
            cc_q <= TCC_DATA_RESET;
            buf_q <= TCC_DATA_RESET;
            ack_q <= 1'b0;
            wb_dat_out <= 32'h0000_0000;
            load_pend_q <= 1'b0;
            eq_prev_q <= 1'b0;
            soft_rise_q <= 1'b0;
            soft_fall_q <= 1'b0;
        end else begin
            ctl_q <= ctl_d;
            cc_q <= cc_d;
            buf_q <= buf_d;
            ack_q <= req;
            wb_dat_out <= rdat_d;
            load_pend_q <= load_pend_d;
            eq_prev_q <= cmp & eq;
            soft_rise_q <= soft_rise_d;
            soft_fall_q <= soft_fall_d;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            act_q <= 1'b0;
            tout_q <= 1'b0;
            match_q <= 1'b0;
            cnt_rst_q <= 1'b0;
            cap_evt_q <= 1'b0;
        end else begin
            act_q <= act_d;
            tout_q <= tout_d;
            match_q <= own_match;
            cnt_rst_q <= cnt_rst_d;
            cap_evt_q <= cap_trig;
        end
    end

    assign wb_ack_out = ack_q;
    assign timer_output_out = tout_q;
    assign match_out = match_q;
    assign counter_reset_out = cnt_rst_q;
    assign capture_event_out = cap_evt_q;

    // Checks
    sequence s_data_write_bl0;
        wr_cc & cmp & (ctl_q.buffer_load_select == TCC_BL_WRITE);
    endsequence

    sequence s_buffer_takes_data;
        ##2 (buf_q == $past(cc_d, 2));
    endsequence

    property p_load_on_write;
        @(posedge clk_in) disable iff (reset_in)
        s_data_write_bl0 |-> s_buffer_takes_data;
    endproperty
    a_load_on_write: assert property (p_load_on_write)
        else $error("buffer missed written value");

    property p_load_at_max_up;
        @(posedge clk_in) disable iff (reset_in)
        (cmp && dir_up && counter_in.at_max &&
         ctl_q.buffer_load_select == TCC_BL_BOUND) |=> (buf_q == $past(cc_q));
    endproperty
    a_load_at_max_up: assert property (p_load_at_max_up)
        else $error("buffer not loaded at MAX");

    property p_reset_on_match;
        @(posedge clk_in) disable iff (reset_in)
        (own_match && ctl_q.buffer_load_select == TCC_BL_MATCH_RST)
        |=> counter_reset_out && $past(counter_in.value) == $past(buf_q);
    endproperty
    a_reset_on_match: assert property (p_reset_on_match)
        else $error("no counter reset on match");

    property p_capture_value;
        @(posedge clk_in) disable iff (reset_in)
        cap_trig |=> capture_event_out && cc_q == $past(counter_in.value);
    endproperty
    a_capture_value: assert property (p_capture_value)
        else $error("captured value wrong");

    property p_capture_disabled;
        @(posedge clk_in) disable iff (reset_in)
        (ctl_q.capture_edge_select == 2'h0 || cmp) |=> !capture_event_out;
    endproperty
    a_capture_disabled: assert property (p_capture_disabled)
        else $error("capture while disabled");

    property p_soft_rise;
        @(posedge clk_in) disable iff (reset_in)
        (soft_rise_d && ctl_wr.channel_mode &&
         ctl_wr.capture_edge_select[0])
        |=> ##1 capture_event_out;
    endproperty
    a_soft_rise: assert property (p_soft_rise)
        else $error("software rising edge not captured");

    property p_sw_level;
        @(posedge clk_in) disable iff (reset_in)
        (cmp && ctl_q.output_mode == TCC_OM_SW)
        |=> timer_output_out == $past(ctl_q.software_output_level);
    endproperty
    a_sw_level: assert property (p_sw_level)
        else $error("software level not driven");

    property p_reset_mode;
        @(posedge clk_in) disable iff (reset_in)
        (own_match && ctl_q.output_mode == TCC_OM_RESET)
        |=> timer_output_out == $past(ctl_q.output_polarity);
    endproperty
    a_reset_mode: assert property (p_reset_mode)
        else $error("output not inactive after match");

    property p_set_mode;
        @(posedge clk_in) disable iff (reset_in)
        (own_match && ctl_q.output_mode == TCC_OM_SET)
        |=> timer_output_out != $past(ctl_q.output_polarity);
    endproperty
    a_set_mode: assert property (p_set_mode)
        else $error("output not active after match");

    property p_capture_holds_output;
        @(posedge clk_in) disable iff (reset_in)
        cap [*2] |-> $stable(timer_output_out);
    endproperty
    a_capture_holds_output: assert property (p_capture_holds_output)
        else $error("output moved in capture mode");
endmodule : tcc_channel

// [verilog/tcc_pkg.sv]
// Constants, field layouts and carriers for one compare/capture channel.
// Assumes a 16-bit shared counter and a 32-bit classic Wishbone slave.
package tcc_pkg;

    localparam int TCC_ADR_W = 4;
    localparam int TCC_CNT_W = 16;
    localparam logic [TCC_ADR_W-1:0] TCC_OFS_CTL = 4'h0;
    localparam logic [TCC_ADR_W-1:0] TCC_OFS_DATA = 4'h4;
    localparam logic [15:0] TCC_CTL_RESET = 16'h0000;
    localparam logic [15:0] TCC_DATA_RESET = 16'h0000;
    localparam logic [15:0] TCC_CTL_WMASK = 16'hff7f;

    // Buffer load timing codes; 0x5..0x7 reserved, never load
    localparam logic [2:0] TCC_BL_WRITE = 3'h0;
    localparam logic [2:0] TCC_BL_BOUND = 3'h1;
    localparam logic [2:0] TCC_BL_MATCH = 3'h2;
    localparam logic [2:0] TCC_BL_RETURN = 3'h3;
    localparam logic [2:0] TCC_BL_MATCH_RST = 3'h4;

    // Capture trigger sources; 0x1 selects nothing
    localparam logic [1:0] TCC_SRC_PIN = 2'h0;
    localparam logic [1:0] TCC_SRC_SW_LO = 2'h2;
    localparam logic [1:0] TCC_SRC_SW_HI = 2'h3;

    // Count direction modes reported by the counter block
    localparam logic [1:0] TCC_DIR_UP = 2'h0;
    localparam logic [1:0] TCC_DIR_DOWN = 2'h1;
    localparam logic [1:0] TCC_DIR_UPDOWN = 2'h2;

    typedef enum logic [2:0] {
        TCC_OM_SW = 3'h0,
        TCC_OM_SET = 3'h1,
        TCC_OM_TOG_RST = 3'h2,
        TCC_OM_SET_RST = 3'h3,
        TCC_OM_TOGGLE = 3'h4,
        TCC_OM_RESET = 3'h5,
        TCC_OM_TOG_SET = 3'h6,
        TCC_OM_RST_SET = 3'h7
    } tcc_omode_t;

    // Control register, bit 15 down to bit 0
    typedef struct packed {
        logic capture_sync_select;
        logic [2:0] buffer_load_select;
        logic [1:0] capture_trigger_source;
        logic [1:0] capture_edge_select;
        logic reserved;
        logic output_pairing;
        logic software_output_level;
        tcc_omode_t output_mode;
        logic output_polarity;
        logic channel_mode;
    } tcc_ctl_t;

    // Shared counter state from the counter block
    typedef struct packed {
        logic [TCC_CNT_W-1:0] value;
        logic [1:0] dir_mode;
        logic at_max;
        logic at_zero;
    } tcc_cnt_t;

endpackage : tcc_pkg

// [verilog/tcc_cap_edge.sv]
// Capture pin edge detector with optional two-stage synchroniser.
// Assumes the pin is a plain level; edges come out as one-cycle pulses.
`timescale 1ns/1ns
module tcc_cap_edge (
    input wire logic clk_in, // channel clock
    input wire logic reset_in, // async reset, active high
    input wire logic pin_in, // capture pin level
    input wire logic sync_sel_in, // 1 selects the synchronised path
    output logic rise_out, // rising edge pulse
    output logic fall_out // falling edge pulse
);
    logic meta_q;
    logic sync_q;
    logic direct_q;
    logic prev_q;
    logic sample;

    // Switching the path while the pin moves may give one false edge
    assign sample = sync_sel_in ? sync_q : direct_q;

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            direct_q <= 1'b0;
            prev_q <= 1'b0;
            rise_out <= 1'b0;
            fall_out <= 1'b0;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
            direct_q <= pin_in;
            prev_q <= sample;
            rise_out <= sample & ~prev_q;
            fall_out <= ~sample & prev_q;
        end
    end
endmodule : tcc_cap_edge

// [verif/tcc_cnt_model.sv]
// Stand-in for the shared counter block feeding the channel.
// Assumes the bench steers run, direction and preloads by NBA on clk_in.
`timescale 1ns/1ns
module tcc_cnt_model import tcc_pkg::*; #(
    parameter logic [15:0] MAX_VAL = 16'h001f
) (
    input wire logic clk_in, // channel clock
    input wire logic reset_in, // async reset, active high
    input wire logic run_in, // count enable
    input wire logic down_in, // 1 counts down
    input wire logic load_in, // preload strobe
    input wire logic [15:0] load_val_in, // preload value
    input wire logic cnt_rst_in, // reset request from the channel
    output tcc_cnt_t counter_out // counter state to the channel
);
    logic [15:0] value_q;
    logic [15:0] value_d;
    assign value_d = down_in ?
        ((value_q == 16'h0000) ? MAX_VAL : value_q - 16'h0001) :
        ((value_q == MAX_VAL) ? 16'h0000 : value_q + 16'h0001);
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            value_q <= 16'h0000;
        end else if (load_in) begin
            value_q <= load_val_in;
        end else if (cnt_rst_in) begin
            value_q <= down_in ? MAX_VAL : 16'h0000;
        end else if (run_in) begin
            value_q <= value_d;
        end
    end
    // Boundary flags only while counting, so a parked counter stays quiet
    assign counter_out = {value_q, down_in ? TCC_DIR_DOWN : TCC_DIR_UP,
        run_in && value_q == MAX_VAL, run_in && value_q == 16'h0000};
endmodule : tcc_cnt_model

// [verif/tcc_channel_test.sv]
// Self-checking bench for one compare/capture channel.
// Assumes the counter stand-in model and a 1-cycle Wishbone ack.
`timescale 1ns/1ns
module tcc_channel_test import tcc_pkg::*;;
    localparam logic [15:0] MAX_VAL = 16'h001f;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, pm = 1'b0, pin = 1'b0;
    logic run = 1'b0, load = 1'b0;
    logic [3:0] adr = 4'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic [15:0] lval = 16'h0, prev_val, c, c2, r;
    logic ack, tout, match, crst, cev;
    tcc_cnt_t cnt;
    int num_errors = 0;
    int num_checks = 0;
    int cyc_n = 0;
    logic [31:0] rd_q[$];
    logic [17:0] note_q[$];
    logic [31:0] seed = 32'd97668;
    logic [2:0] om [7] = '{3'h5, 3'h4, 3'h7, 3'h6, 3'h1, 3'h2, 3'h3};
    logic o1 [7] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1};
    logic o2 [7] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1};

    initial forever #2 clk_in = ~clk_in;

    tcc_channel u_tcc_channel (.clk_in(clk_in), .reset_in(reset_in),
        .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
        .wb_sel_in(4'h3), .wb_dat_in(wdat), .wb_dat_out(rdat),
        .wb_ack_out(ack), .counter_in(cnt), .partner_match_in(pm),
        .capture_input_pin_in(pin), .timer_output_out(tout),
        .match_out(match), .counter_reset_out(crst),
        .capture_event_out(cev));
    tcc_cnt_model #(.MAX_VAL(MAX_VAL)) u_tcc_cnt_model (.clk_in(clk_in),
        .reset_in(reset_in), .run_in(run), .down_in(1'b0), .load_in(load),
        .load_val_in(lval), .cnt_rst_in(crst), .counter_out(cnt));

    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_rd

    task automatic cmp_pin(input logic [17:0] got, input logic [17:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp_pin

    task automatic nxt;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
    endtask : nxt

    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [15:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= {16'h0000, d};
        do begin
            @(posedge clk_in);
            n++;
        end while (ack !== 1'b1 && n < 20);
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n == 20) begin
            num_errors++;
            summarize();
        end
    endtask : wb

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        wb(1'b0, a, 16'h0000);
    endtask : rd

    task automatic note(input logic rst, input logic o, input logic [15:0] v);
        note_q.push_back({rst, o, v});
    endtask : note

    task automatic setc(input logic [15:0] v);
        @(posedge clk_in);
        run <= 1'b0;
        load <= 1'b1;
        lval <= v;
        @(posedge clk_in);
        load <= 1'b0;
    endtask : setc

    // Count until every noted match has been seen, then park at zero
    task automatic spin;
        int n;
        n = 0;
        @(posedge clk_in);
        run <= 1'b1;
        while (note_q.size() > 0 && n < 300) begin
            @(posedge clk_in);
            n++;
        end
        if (n == 300) begin
            num_errors++;
            summarize();
        end
        setc(16'h0000);
    endtask : spin

    task automatic wait_ev(input logic e);
        logic seen;
        seen = 1'b0;
        repeat (10) begin
            @(posedge clk_in);
            if (cev === 1'b1) seen = 1'b1;
        end
        cmp_pin({17'h0, seen}, {17'h0, e});
    endtask : wait_ev

    always @(posedge clk_in) begin
        if (ack === 1'b1 && !we && rd_q.size() > 0)
            cmp_rd(rdat, rd_q.pop_front());
        if (match === 1'b1 && note_q.size() > 0)
            cmp_pin({crst, tout, prev_val}, note_q.pop_front());
        prev_val <= cnt.value;
        cyc_n++;
        if (cyc_n == 20000) begin
            num_errors++;
            summarize();
        end
    end

    initial begin
        repeat (6) @(posedge clk_in);
        reset_in <= 1'b0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        wb(1'b1, 4'h0, 16'hffff);
        rd(4'h0, 32'h0000ff7f);
        wb(1'b1, 4'h8, 16'h1234);
        rd(4'h4, 32'h0);
        // Polarity set on purpose: software level must win in mode 0
        wb(1'b1, 4'h0, 16'h0022);
        repeat (3) @(posedge clk_in);
        cmp_pin({17'h0, tout}, 18'h1);
        wb(1'b1, 4'h0, 16'h0000);
        repeat (3) @(posedge clk_in);
        cmp_pin({17'h0, tout}, 18'h0);
        nxt();
        c = 16'h0001 + 16'(seed % 32'd30);
        c2 = (c % 16'd30) + 16'h0001;
        wb(1'b1, 4'h4, c);
        for (int i = 0; i < 7; i++) begin
            wb(1'b1, 4'h0, 16'(om[i]) << 2);
            note(1'b0, o1[i], c);
            note(1'b0, o2[i], c);
            spin();
        end
        wb(1'b1, 4'h0, 16'h000e);
        note(1'b0, 1'b0, c);
        note(1'b0, 1'b0, c);
        spin();
        wb(1'b1, 4'h0, 16'h005c);
        note(1'b0, 1'b0, c);
        spin();
        // Own match left the output inactive; only the partner can raise it
        @(posedge clk_in) pm <= 1'b1;
        @(posedge clk_in) pm <= 1'b0;
        repeat (3) @(posedge clk_in);
        cmp_pin({17'h0, tout}, 18'h1);
        wb(1'b1, 4'h0, 16'h2004);
        wb(1'b1, 4'h4, c2);
        note(1'b0, 1'b1, c);
        note(1'b0, 1'b1, c2);
        spin();
        wb(1'b1, 4'h0, 16'h4004);
        wb(1'b1, 4'h4, c);
        note(1'b1, 1'b1, c2);
        note(1'b1, 1'b1, c);
        spin();
        wb(1'b1, 4'h0, 16'h1004);
        wb(1'b1, 4'h4, c2);
        note(1'b0, 1'b1, c);
        note(1'b0, 1'b1, c2);
        spin();
        // Start past zero so the old value must match before the reload
        wb(1'b1, 4'h0, 16'h3004);
        wb(1'b1, 4'h4, c);
        setc(16'h0001);
        note(1'b0, 1'b1, c2);
        note(1'b0, 1'b1, c);
        spin();
        nxt();
        r = seed[15:0] | 16'h0100;
        setc(r);
        wb(1'b1, 4'h0, 16'h0101);
        @(posedge clk_in) pin <= 1'b1;
        wait_ev(1'b1);
        rd(4'h4, {16'h0, r});
        nxt();
        r = seed[15:0] | 16'h0100;
        setc(r);
        wb(1'b1, 4'h0, 16'h8201);
        @(posedge clk_in) pin <= 1'b0;
        wait_ev(1'b1);
        rd(4'h4, {16'h0, r});
        @(posedge clk_in) pin <= 1'b1;
        wait_ev(1'b0);
        nxt();
        r = seed[15:0] | 16'h0100;
        setc(r);
        wb(1'b1, 4'h0, 16'h0901);
        wb(1'b1, 4'h0, 16'h0d01);
        wait_ev(1'b1);
        rd(4'h4, {16'h0, r});
        setc(16'h0155);
        wb(1'b1, 4'h0, 16'h0c01);
        wb(1'b1, 4'h0, 16'h0801);
        wait_ev(1'b0);
        rd(4'h4, {16'h0, r});
        wb(1'b1, 4'h0, 16'h0b01);
        wb(1'b1, 4'h0, 16'h0f01);
        wait_ev(1'b1);
        setc(16'h0177);
        wb(1'b1, 4'h0, 16'h0b01);
        wait_ev(1'b1);
        rd(4'h4, 32'h00000177);
        wb(1'b1, 4'h0, 16'h0b00);
        wb(1'b1, 4'h0, 16'h0f00);
        wait_ev(1'b0);
        rd(4'h4, 32'h00000177);
        summarize();
    end
endmodule : tcc_channel_test
